// File: rtl/clock_reset_option_pkg.sv
package clock_reset_option_pkg;
    // oscillator source choices
    localparam logic [1:0] OSC_EXT_CLOCK = 2'h0;
    localparam logic [1:0] OSC_RC_TWO_PIN = 2'h1;
    localparam logic [1:0] OSC_CERAMIC = 2'h2;
    // predivider choices
    localparam logic [1:0] DIV_ONE = 2'h0;
    localparam logic [1:0] DIV_THREE = 2'h1;
    localparam logic [1:0] DIV_FOUR = 2'h2;
    localparam logic [2:0] DIV_ONE_COUNT = 3'h1;
    localparam logic [2:0] DIV_THREE_COUNT = 3'h3;
    localparam logic [2:0] DIV_FOUR_COUNT = 3'h4;
    // timing
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int RESET_LOW_SYS_CYCLES = 4;
    localparam logic [1:0] CYCLE_SYS_LAST = 2'h3;
    localparam int BURST_PERIOD_TCYC = 64;
    localparam logic [5:0] BURST_HALF_LAST = 6'h1f;
    localparam logic [2:0] RESET_FILTER_LAST = 3'h3;
    localparam logic [3:0] SERIAL_LEN_SHORT = 4'h4;
    localparam logic [3:0] SERIAL_LEN_LONG = 4'h8;
    // wishbone register offsets (byte addresses)
    localparam logic [7:0] REG_PORT_CTRL = 8'h00;
    localparam logic [7:0] REG_PORT_DATA = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    // control register fields
    localparam int CTRL_SERIAL_EN = 0;
    localparam int CTRL_SERIAL_LONG = 1;
    localparam int CTRL_INT_EN = 2;
    localparam int CTRL_BURST_EN = 3;
    localparam int CTRL_HALT = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0;
    localparam logic [31:0] DATA_RESET = 32'h0;
endpackage : clock_reset_option_pkg

// File: rtl/clock_reset_option_logic.sv
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module clock_reset_option_logic #(
    parameter logic [1:0] OSC_SELECT = 2'h0,
    parameter logic [1:0] DIV_SELECT = 2'h0,
    parameter logic RESET_HIGH_C = 1'b1,
    parameter logic RESET_HIGH_D = 1'b1,
    parameter logic [24:0] PULLUP_BITS = 25'h0,
    parameter logic STANDBY_WHOLE_PORT = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic resetInN,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic [24:0] pinIn,
    output logic [24:0] pinOut,
    output logic [24:0] pinOe,
    output logic [24:0] pullupEn,
    output logic secondOscTerminal,
    output logic systemReset,
    output logic instrStrobe,
    output logic standbyActive,
    output logic extIntReq,
    output logic serialDone
);
    // pin map: 0-3 standby port, 4-7 port C, 8-11 port D, 12-15 burst port,
    // 16-19 shared serial port, 20-23 port G, 24 shared oscillator bit
    typedef struct packed {
        logic [2:0] divCnt;
        logic [1:0] phase;
        logic [5:0] burstCnt;
        logic burstLevel;
        logic [2:0] resetLowCnt;
        logic resetHold;
        logic [31:0] ctrl;
        logic [31:0] data;
        logic halted;
        logic ack;
        logic [31:0] rdata;
        logic [2:0] intSync;
        logic extInt;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic serialBusy;
        logic done;
    } state_t;
    state_t cur_ff, nxt_ff;
    logic [2:0] divLimit;
    logic sysTick;
    logic instrTick;
    logic wakeUp;
    logic sckRise;
    logic [31:0] statusWord;

    // divide count fixed by option; RC is forced undivided
    always_comb begin
        if (OSC_SELECT == clock_reset_option_pkg::OSC_RC_TWO_PIN) begin
            divLimit = clock_reset_option_pkg::DIV_ONE_COUNT;
        end else if (DIV_SELECT == clock_reset_option_pkg::DIV_THREE) begin
            divLimit = clock_reset_option_pkg::DIV_THREE_COUNT;
        end else if (DIV_SELECT == clock_reset_option_pkg::DIV_FOUR) begin
            divLimit = clock_reset_option_pkg::DIV_FOUR_COUNT;
        end else begin
            divLimit = clock_reset_option_pkg::DIV_ONE_COUNT;
        end
    end

    assign sysTick = (cur_ff.divCnt == divLimit - 3'h1);
    assign instrTick = sysTick && (cur_ff.phase == clock_reset_option_pkg::CYCLE_SYS_LAST);
    assign wakeUp = STANDBY_WHOLE_PORT ? (pinIn[3:0] != 4'h0) : pinIn[3];
    assign sckRise = cur_ff.intSync[1] & ~cur_ff.intSync[2];
    assign statusWord = {25'h0, cur_ff.serialBusy, cur_ff.done, cur_ff.extInt,
        cur_ff.resetHold, cur_ff.halted, cur_ff.burstLevel, 1'b0};

    // next state
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.ack = 1'b0;
        nxt_ff.divCnt = sysTick ? 3'h0 : cur_ff.divCnt + 3'h1;
        if (sysTick) begin
            nxt_ff.phase = cur_ff.phase + 2'h1;
            // reset filter counts system clocks of low input
            if (!resetInN) begin
                if (cur_ff.resetLowCnt == clock_reset_option_pkg::RESET_FILTER_LAST) begin
                    nxt_ff.resetHold = 1'b1;
                end else begin
                    nxt_ff.resetLowCnt = cur_ff.resetLowCnt + 3'h1;
                end
            end else begin
                nxt_ff.resetLowCnt = 3'h0;
                nxt_ff.resetHold = 1'b0;
            end
        end
        // burst pulse: 32 cycles high, 32 low
        if (instrTick) begin
            if (cur_ff.burstCnt == clock_reset_option_pkg::BURST_HALF_LAST) begin
                nxt_ff.burstCnt = 6'h0;
                nxt_ff.burstLevel = ~cur_ff.burstLevel;
            end else begin
                nxt_ff.burstCnt = cur_ff.burstCnt + 6'h1;
            end
        end
        // standby release on wake-up (entry is by the halt bit of a control register write)
        if (cur_ff.halted && wakeUp) begin
            nxt_ff.halted = 1'b0;
        end
        // external interrupt and serial clock sampling on shared port
        nxt_ff.intSync = {cur_ff.intSync[1:0], pinIn[18]};
        if (cur_ff.ctrl[clock_reset_option_pkg::CTRL_INT_EN] && pinIn[19]) begin
            nxt_ff.extInt = 1'b1;
        end
        if (cur_ff.serialBusy && sckRise) begin
            nxt_ff.shift = {cur_ff.shift[6:0], pinIn[16]};
            nxt_ff.bitCnt = cur_ff.bitCnt - 4'h1;
            if (cur_ff.bitCnt == 4'h1) begin
                nxt_ff.serialBusy = 1'b0;
                nxt_ff.done = 1'b1;
            end
        end
        // wishbone slave, one wait state
        if (wb_cyc_i && wb_stb_i && !cur_ff.ack) begin
            nxt_ff.ack = 1'b1;
            unique case (wb_adr_i[7:0])
                clock_reset_option_pkg::REG_PORT_CTRL: nxt_ff.rdata = cur_ff.ctrl;
                clock_reset_option_pkg::REG_PORT_DATA: nxt_ff.rdata = cur_ff.data;
                clock_reset_option_pkg::REG_STATUS: nxt_ff.rdata = statusWord;
                default: nxt_ff.rdata = 32'h0;
            endcase
            if (wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i[7:0] == clock_reset_option_pkg::REG_PORT_CTRL) begin
                    nxt_ff.ctrl[7:0] = wb_dat_i[7:0];
                    nxt_ff.halted = wb_dat_i[clock_reset_option_pkg::CTRL_HALT];
                    if (wb_dat_i[clock_reset_option_pkg::CTRL_SERIAL_EN]) begin
                        nxt_ff.serialBusy = 1'b1;
                        nxt_ff.bitCnt = wb_dat_i[clock_reset_option_pkg::CTRL_SERIAL_LONG]
                            ? clock_reset_option_pkg::SERIAL_LEN_LONG
                            : clock_reset_option_pkg::SERIAL_LEN_SHORT;
                    end
                end else if (wb_adr_i[7:0] == clock_reset_option_pkg::REG_STATUS) begin
                    // write one clears; a same-cycle event wins
                    if (wb_dat_i[3] && !(cur_ff.ctrl[clock_reset_option_pkg::CTRL_INT_EN] && pinIn[19])) begin
                        nxt_ff.extInt = 1'b0;
                    end
                    if (wb_dat_i[4] && !(cur_ff.serialBusy && sckRise && cur_ff.bitCnt == 4'h1)) begin
                        nxt_ff.done = 1'b0;
                    end
                end
            end
            if (wb_we_i && wb_adr_i[7:0] == clock_reset_option_pkg::REG_PORT_DATA) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        nxt_ff.data[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    end
                end
            end
        end
        if (cur_ff.resetHold) begin
            nxt_ff.ctrl = clock_reset_option_pkg::CTRL_RESET;
            nxt_ff.data = clock_reset_option_pkg::DATA_RESET;
            nxt_ff.halted = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // per-pin drive: low drive only, release means high
    genvar g;
    generate
        for (g = 0; g < 25; g++) begin : g_pin
            logic wantHigh;
            always_comb begin
                if (cur_ff.resetHold && g >= 4 && g < 8) begin
                    wantHigh = RESET_HIGH_C;
                end else if (cur_ff.resetHold && g >= 8 && g < 12) begin
                    wantHigh = RESET_HIGH_D;
                end else if (cur_ff.resetHold) begin
                    wantHigh = 1'b1;
                end else if (g == 12 && cur_ff.ctrl[clock_reset_option_pkg::CTRL_BURST_EN]) begin
                    wantHigh = cur_ff.burstLevel;
                end else if (g == 17 && cur_ff.serialBusy) begin
                    wantHigh = cur_ff.shift[7];
                end else begin
                    wantHigh = cur_ff.data[g];
                end
            end
            if (g == 24) begin : g_shared
                // two-pin oscillator takes the pin from the port
                assign pinOe[g] = (OSC_SELECT != clock_reset_option_pkg::OSC_EXT_CLOCK) ? 1'b1 : wantHigh;
                assign pinOut[g] = 1'b0;
                assign pullupEn[g] = (OSC_SELECT == clock_reset_option_pkg::OSC_EXT_CLOCK)
                    && PULLUP_BITS[g];
            end else begin : g_port
                assign pinOe[g] = wantHigh;
                assign pinOut[g] = 1'b0;
                assign pullupEn[g] = PULLUP_BITS[g];
            end
        end
    endgenerate

    assign secondOscTerminal = (OSC_SELECT != clock_reset_option_pkg::OSC_EXT_CLOCK);
    assign systemReset = cur_ff.resetHold;
    assign instrStrobe = instrTick;
    assign standbyActive = cur_ff.halted;
    assign extIntReq = cur_ff.extInt;
    assign serialDone = cur_ff.done;
    assign wb_ack_o = cur_ff.ack;
    assign wb_dat_o = cur_ff.rdata;

    // checks
    a_div_period: assert property (@(posedge clock) disable iff (rst)
        sysTick |=> !sysTick [*2] ##1 sysTick or
        divLimit != clock_reset_option_pkg::DIV_THREE_COUNT) else $error("divide by three broken");
    a_rc_undivided: assert property (@(posedge clock) disable iff (rst)
        OSC_SELECT == clock_reset_option_pkg::OSC_RC_TWO_PIN |-> sysTick) else $error("rc divided");
    a_reset_level: assert property (@(posedge clock) disable iff (rst)
        cur_ff.resetHold |-> pinOe[7:4] == {4{RESET_HIGH_C}}) else $error("reset level wrong");
    a_pullup_map: assert property (@(posedge clock) disable iff (rst)
        pullupEn[23:0] == PULLUP_BITS[23:0]) else $error("pullup map wrong");
    a_shared_osc: assert property (@(posedge clock) disable iff (rst)
        secondOscTerminal |-> pinOe[24] && !pullupEn[24]) else $error("shared pin driven");
    a_instr_four: assert property (@(posedge clock) disable iff (rst)
        instrTick |-> $past(cur_ff.phase) == 2'h2 || divLimit != clock_reset_option_pkg::DIV_ONE_COUNT)
        else $error("instruction cycle length");
    a_burst_toggle: assert property (@(posedge clock) disable iff (rst)
        instrTick && cur_ff.burstCnt == 6'h1f |=> $changed(cur_ff.burstLevel)) else $error("burst half");
    a_wake_release: assert property (@(posedge clock) disable iff (rst)
        cur_ff.halted && wakeUp && !cur_ff.resetHold && !(wb_cyc_i && wb_stb_i) |=> !standbyActive)
        else $error("standby not released");
    a_serial_len: assert property (@(posedge clock) disable iff (rst)
        cur_ff.serialBusy |-> cur_ff.bitCnt <= 4'h8 && cur_ff.bitCnt != 4'h0) else $error("serial len");
    a_int_latch: assert property (@(posedge clock) disable iff (rst)
        cur_ff.ctrl[2] && pinIn[19] |=> extIntReq) else $error("interrupt lost");
    a_reset_filter: assert property (@(posedge clock) disable iff (rst)
        $rose(systemReset) |-> $past(cur_ff.resetLowCnt) == 3'h3) else $error("reset too early");
    c_burst: cover property (@(posedge clock) $rose(cur_ff.burstLevel));
    c_wake: cover property (@(posedge clock) $fell(standbyActive));
    c_serial: cover property (@(posedge clock) $rose(serialDone));
    c_reset: cover property (@(posedge clock) $rose(systemReset));
endmodule : clock_reset_option_logic
`default_nettype wire

// File: test/board_partner.sv
`timescale 1ns/10ps
`default_nettype none
module board_partner (
    input wire logic clock,
    input wire logic resetReq,
    input wire logic [24:0] pinOe,
    input wire logic [24:0] extLevel,
    output logic resetInN,
    output logic [24:0] pinIn
);
    int holdCnt = 0;
    // reset pin held low 16 source cycles, above four system ticks
    always @(posedge clock) begin
        if (resetReq) holdCnt <= 16;
        else if (holdCnt > 0) holdCnt <= holdCnt - 1;
    end
    assign resetInN = (holdCnt == 0);
    // sunk while enable low, else board level, held steady by the bench
    assign pinIn = pinOe & extLevel;
endmodule : board_partner
`default_nettype wire

// File: test/clock_reset_option_logic_tb.sv
`timescale 1ns/10ps
`default_nettype none
module clock_reset_option_logic_tb;
    localparam logic [24:0] PULL = 25'h1a5a5a5;
    localparam logic [7:0] CTRL = clock_reset_option_pkg::REG_PORT_CTRL;
    localparam logic [7:0] STAT = clock_reset_option_pkg::REG_STATUS;
    localparam logic [31:0] SER = 32'h1 << clock_reset_option_pkg::CTRL_SERIAL_EN;
    localparam logic [31:0] LONG = 32'h1 << clock_reset_option_pkg::CTRL_SERIAL_LONG;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wbAck, resetReq = 1'b0, resetInN;
    logic [3:0] sel = 4'h0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, wbDatO, rdat, seed = 32'h066b;
    logic [24:0] extLevel = 25'h1ffffff, pinIn, pinOe, pullupEn, pinOut, pinOeRc, pullupEnRc;
    logic secondOsc, systemReset, instrStrobe, standbyActive, extIntReq, serialDone;
    logic secondOscRc, strobeRc, standbyRc;
    logic q[$];
    int error_cnt = 0, num_checks = 0, n, k, left;
    clock_reset_option_logic #(.OSC_SELECT(clock_reset_option_pkg::OSC_EXT_CLOCK),
        .DIV_SELECT(clock_reset_option_pkg::DIV_THREE), .RESET_HIGH_C(1'b1), .RESET_HIGH_D(1'b0),
        .PULLUP_BITS(PULL), .STANDBY_WHOLE_PORT(1'b0)) dut (.clock(clock), .rst(rst),
        .resetInN(resetInN), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(wbDatO), .wb_we_i(we),
        .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(wbAck), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn), .secondOscTerminal(secondOsc),
        .systemReset(systemReset), .instrStrobe(instrStrobe), .standbyActive(standbyActive),
        .extIntReq(extIntReq), .serialDone(serialDone));
    // second build: two-pin rc source, whole-port standby release
    clock_reset_option_logic #(.OSC_SELECT(clock_reset_option_pkg::OSC_RC_TWO_PIN),
        .DIV_SELECT(clock_reset_option_pkg::DIV_FOUR), .RESET_HIGH_C(1'b0), .RESET_HIGH_D(1'b1),
        .PULLUP_BITS(PULL), .STANDBY_WHOLE_PORT(1'b1)) dutRc (.clock(clock), .rst(rst),
        .resetInN(resetInN), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(), .wb_we_i(we),
        .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(), .pinIn(pinIn),
        .pinOut(), .pinOe(pinOeRc), .pullupEn(pullupEnRc), .secondOscTerminal(secondOscRc),
        .systemReset(), .instrStrobe(strobeRc), .standbyActive(standbyRc),
        .extIntReq(), .serialDone());
    board_partner board (.clock(clock), .resetReq(resetReq), .pinOe(pinOe), .extLevel(extLevel),
        .resetInN(resetInN), .pinIn(pinIn));
    // source clock, 100 ns period
    always #50 clock = ~clock;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= {24'h0, a};
        wdat <= d;
        do begin
            @(posedge clock);
            t++;
        end while (wbAck !== 1'b1 && t < 50);
        rdat = wbDatO;
        if (t >= 50) error_cnt++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic waitStrobe(input logic rc, output int c);
        c = 0;
        do begin
            @(posedge clock);
            c++;
        end while ((rc ? strobeRc : instrStrobe) !== 1'b1 && c < 200);
    endtask : waitStrobe
    // instruction cycles between two changes of the burst pin
    task automatic burstHalf(output int c);
        logic prev;
        int t;
        prev = pinOe[12];
        c = 0;
        t = 0;
        while (pinOe[12] === prev && t < 3000) begin
            @(posedge clock);
            t++;
            if (instrStrobe === 1'b1) c++;
        end
    endtask : burstHalf
    // serial clock pin pulses with random data, idle high; the queue models the shifter
    task automatic pulses(input int c);
        repeat (c) begin
            seed = lfsr(seed);
            extLevel[16] <= seed[0];
            extLevel[18] <= 1'b0;
            repeat (8) @(posedge clock);
            extLevel[18] <= 1'b1;
            repeat (8) @(posedge clock);
            q.push_back(seed[0]);
            left--;
            check(serialDone, left == 0);
            check(pinOe[17], left > 0 ? q[q.size() - 8] : 1'b1);
        end
    endtask : pulses
    task automatic summarize;
        $display("errors=%0d checks=%0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    // watchdog
    initial begin
        #(20000 * 100);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        check(pullupEn, PULL);
        check(secondOsc, 1'b0);
        check(pinOut, 25'h0);
        check(pullupEnRc, {1'b0, PULL[23:0]});
        check(secondOscRc, 1'b1);
        check(pinOeRc[24], 1'b1);
        waitStrobe(1'b0, n);
        waitStrobe(1'b0, n);
        check(n, 12);
        waitStrobe(1'b1, n);
        waitStrobe(1'b1, n);
        check(n, 4);
        seed = lfsr(seed);
        wb(1'b1, 8'h40, seed);
        wb(1'b0, 8'h40, 32'h0);
        check(rdat, 32'h0);
        wb(1'b1, clock_reset_option_pkg::REG_PORT_DATA, 32'h01ffffff);
        wb(1'b1, CTRL, 32'h1 << clock_reset_option_pkg::CTRL_BURST_EN);
        wb(1'b0, CTRL, 32'h0);
        check(rdat[3], 1'b1);
        burstHalf(k);
        burstHalf(k);
        check(k, 32);
        burstHalf(k);
        check(k, 32);
        // board reset pin restart
        @(posedge clock);
        resetReq <= 1'b1;
        @(posedge clock);
        resetReq <= 1'b0;
        n = 0;
        while (systemReset !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        check(systemReset, 1'b1);
        check(pinOe[11:4], 8'h0f);
        check(pinOeRc[11:4], 8'hf0);
        while (resetInN !== 1'b1 || systemReset !== 1'b0) @(posedge clock);
        wb(1'b0, CTRL, 32'h0);
        check(rdat, clock_reset_option_pkg::CTRL_RESET);
        wb(1'b0, clock_reset_option_pkg::REG_PORT_DATA, 32'h0);
        check(rdat, clock_reset_option_pkg::DATA_RESET);
        check(pinOe[24], 1'b0);
        check(pinOeRc[24], 1'b1);
        // release the port pins again after the restart cleared them
        wb(1'b1, clock_reset_option_pkg::REG_PORT_DATA, 32'h01ffffff);
        // halt standby and its release
        extLevel[3] <= 1'b0;
        wb(1'b1, CTRL, 32'h1 << clock_reset_option_pkg::CTRL_HALT);
        repeat (2) @(posedge clock);
        check(standbyActive, 1'b1);
        check(standbyRc, 1'b0);
        extLevel[3] <= 1'b1;
        repeat (20) @(posedge clock);
        check(standbyActive, 1'b0);
        // interrupt input and its clear, pin low while clearing
        extLevel[19] <= 1'b0;
        wb(1'b1, CTRL, 32'h1 << clock_reset_option_pkg::CTRL_INT_EN);
        repeat (10) @(posedge clock);
        check(extIntReq, 1'b0);
        extLevel[19] <= 1'b1;
        repeat (4) @(posedge clock);
        check(extIntReq, 1'b1);
        extLevel[19] <= 1'b0;
        wb(1'b1, STAT, 32'h8);
        check(extIntReq, 1'b0);
        // four and eight bit transfers
        repeat (8) q.push_back(1'b0);
        left = 4;
        wb(1'b1, CTRL, SER);
        pulses(4);
        check(serialDone, 1'b1);
        wb(1'b1, STAT, 32'h10);
        left = 8;
        wb(1'b1, CTRL, SER | LONG);
        pulses(4);
        check(serialDone, 1'b0);
        pulses(4);
        check(serialDone, 1'b1);
        summarize();
    end
endmodule : clock_reset_option_logic_tb
`default_nettype wire
